// file: hdl/sia_alias_load.sv
// first-load-only capture of the alias from configuration memory
module sia_alias_load
  (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration memory load
  input wire logic cfg_load,
  // result
  output logic take
);
  logic loaded_reg;

  // only a power-on reset clears this, so later reloads are ignored
  assign take = cfg_load && !loaded_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      loaded_reg <= 1'b0;
    else if (cfg_load)
      loaded_reg <= 1'b1;
  end

  AST_ONE_LOAD: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(cfg_load) |-> !take)
    else $error("alias loaded twice");
endmodule

// file: hdl/sia_pkg.sv
// constants and carrier types for the slave identity/address register bank
package sia_pkg;
  // byte offsets
  localparam logic [15:0] SIA_OFS_TYPE = 16'h0000;
  localparam logic [15:0] SIA_OFS_REV = 16'h0001;
  localparam logic [15:0] SIA_OFS_BUILD_LO = 16'h0002;
  localparam logic [15:0] SIA_OFS_BUILD_HI = 16'h0003;
  localparam logic [15:0] SIA_OFS_MAPCNT = 16'h0004;
  localparam logic [15:0] SIA_OFS_BUFCNT = 16'h0005;
  localparam logic [15:0] SIA_OFS_RAMKB = 16'h0006;
  localparam logic [15:0] SIA_OFS_PORTS = 16'h0007;
  localparam logic [15:0] SIA_OFS_FEAT_LO = 16'h0008;
  localparam logic [15:0] SIA_OFS_FEAT_HI = 16'h0009;
  localparam logic [15:0] SIA_OFS_NODE_LO = 16'h0010;
  localparam logic [15:0] SIA_OFS_NODE_HI = 16'h0011;
  localparam logic [15:0] SIA_OFS_ALIAS_LO = 16'h0012;
  localparam logic [15:0] SIA_OFS_ALIAS_HI = 16'h0013;
  localparam logic [15:0] SIA_OFS_UNLOCK = 16'h0020;
  // protected windows
  localparam logic [15:0] SIA_PROT_A_LO = 16'h0000;
  localparam logic [15:0] SIA_PROT_A_HI = 16'h0137;
  localparam logic [15:0] SIA_PROT_B_LO = 16'h013A;
  localparam logic [15:0] SIA_PROT_B_HI = 16'h0F0F;
  // identity values, arbitrary neutral codes
  localparam logic [7:0] SIA_TYPE_VAL = 8'h5A;
  localparam logic [7:0] SIA_REV_VAL = 8'h01;
  localparam logic [15:0] SIA_BUILD_VAL = 16'h0001;
  // capability values
  localparam logic [7:0] SIA_MAPCNT_VAL = 8'h08;
  localparam logic [7:0] SIA_BUFCNT_VAL = 8'h08;
  localparam logic [7:0] SIA_RAMKB_VAL = 8'h10;
  localparam logic [1:0] SIA_PORT_NONE = 2'h0;
  localparam logic [1:0] SIA_PORT_UNCFG = 2'h1;
  localparam logic [1:0] SIA_PORT_DIFF = 2'h2;
  localparam logic [1:0] SIA_PORT_MII = 2'h3;
  localparam int SIA_PORT0_POS = 0;
  localparam int SIA_PORT1_POS = 2;
  // feature bit positions
  localparam int SIA_FB_BYTE_MAP = 0;
  localparam int SIA_FB_DC = 2;
  localparam int SIA_FB_DC64 = 3;
  localparam int SIA_FB_LJ_DIFF = 4;
  localparam int SIA_FB_ELD_DIFF = 5;
  localparam int SIA_FB_ELD_MII = 6;
  localparam int SIA_FB_FCS_SEP = 7;
  localparam int SIA_FB_SYNC_ACT = 8;
  localparam int SIA_FB_NO_LRW = 9;
  localparam int SIA_FB_NO_RW = 10;
  localparam int SIA_FB_FIXED = 11;
  localparam int SIA_ALIAS_EN_BIT = 24;
  localparam logic [15:0] SIA_NODE_RST = 16'h0000;
  localparam logic [15:0] SIA_ALIAS_RST = 16'h0000;

  // one byte access from either agent
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sia_req_t;

  typedef enum logic [1:0] {SIA_SRC_NET, SIA_SRC_HOST} sia_src_t;
endpackage

// file: hdl/sia_regs.sv
// identification, node address, alias and write unlock register bank
// Function
// - read-only type code at offset zero
// - read-only revision code at offset one
// - read-only 16-bit build, low byte first
// - mapping channel count reads eight
// - buffer manager count reads eight
// - process ram size reads sixteen kilobytes
// - port descriptor: both ports media-independent, top zero
// - feature bits four and five read zero
// - feature bit seven: separate checksum error counting
// - feature bit eight: enhanced sync-output activation
// - feature bit nine zero: combined command supported
// - feature bit ten zero: read/write commands supported
// - feature bit eleven: fixed or variable configuration
// - node address: network writes, host reads
// - alias: host writes; used when control bit set
// - alias loads only at first configuration load
// - protected writes blocked until unlock in frame
// - protection stays active after the frame
// - protected ranges exclude 0138-0139 and addresses above 0F0F; the unlock register stays writable
module sia_regs
  import sia_pkg::*;
#(
  parameter logic FEAT_BYTE_MAP = 1'b1,
  parameter logic FEAT_DC = 1'b1,
  parameter logic FEAT_DC64 = 1'b1,
  parameter logic FEAT_ELD_MII = 1'b1,
  parameter logic FEAT_FCS_SEP = 1'b1,
  parameter logic FEAT_SYNC_ACT = 1'b1,
  parameter logic FEAT_FIXED = 1'b0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // network side access
  input wire sia_pkg::sia_req_t net_req,
  input wire logic net_frame_end,
  output logic [7:0] net_rdata,
  output logic net_wr_done,
  // local host port access
  input wire sia_pkg::sia_req_t host_req,
  output logic [7:0] host_rdata,
  // configuration memory load and link control
  input wire logic cfg_load,
  input wire logic [15:0] cfg_alias,
  input wire logic [31:0] link_ctrl,
  input wire logic prot_en,
  // address matching
  output logic [15:0] node_addr,
  output logic [15:0] match_alias,
  output logic alias_active
);
  import sia_pkg::*;

  logic [15:0] node_reg;
  logic [15:0] node_next;
  logic [15:0] alias_reg;
  logic [15:0] alias_next;
  logic [7:0] net_rdata_reg;
  logic [7:0] host_rdata_reg;
  logic net_done_reg;
  logic [15:0] feat;
  logic [7:0] ports;
  logic wr_allow;
  logic unlocked;
  logic alias_take;
  logic net_wr_ok;

  sia_wr_gate u_gate (
    .clk(clk),
    .rst_b(rst_b),
    .frame_end(net_frame_end),
    .net_wr(net_req.wr),
    .net_addr(net_req.addr),
    .prot_en(prot_en),
    .wr_allow(wr_allow),
    .unlocked(unlocked)
  );

  sia_alias_load u_alias (
    .clk(clk),
    .rst_b(rst_b),
    .cfg_load(cfg_load),
    .take(alias_take)
  );

  always_comb
  begin
    feat = 16'h0000;
    feat[SIA_FB_BYTE_MAP] = FEAT_BYTE_MAP;
    feat[SIA_FB_DC] = FEAT_DC;
    feat[SIA_FB_DC64] = FEAT_DC64;
    feat[SIA_FB_LJ_DIFF] = 1'b0;
    feat[SIA_FB_ELD_DIFF] = 1'b0;
    feat[SIA_FB_ELD_MII] = FEAT_ELD_MII;
    feat[SIA_FB_FCS_SEP] = FEAT_FCS_SEP;
    feat[SIA_FB_SYNC_ACT] = FEAT_SYNC_ACT;
    feat[SIA_FB_NO_LRW] = 1'b0;
    feat[SIA_FB_NO_RW] = 1'b0;
    feat[SIA_FB_FIXED] = FEAT_FIXED;
  end

  always_comb
  begin
    ports = 8'h00;
    ports[SIA_PORT0_POS +: 2] = SIA_PORT_MII;
    ports[SIA_PORT1_POS +: 2] = SIA_PORT_MII;
  end

  // shared read decode; both agents see the same values
  function automatic logic [7:0] rd_byte(input logic [15:0] a,
    input logic [15:0] fe, input logic [7:0] pd,
    input logic [15:0] nd, input logic [15:0] al);
    case (a)
      SIA_OFS_TYPE: rd_byte = SIA_TYPE_VAL;
      SIA_OFS_REV: rd_byte = SIA_REV_VAL;
      SIA_OFS_BUILD_LO: rd_byte = SIA_BUILD_VAL[7:0];
      SIA_OFS_BUILD_HI: rd_byte = SIA_BUILD_VAL[15:8];
      SIA_OFS_MAPCNT: rd_byte = SIA_MAPCNT_VAL;
      SIA_OFS_BUFCNT: rd_byte = SIA_BUFCNT_VAL;
      SIA_OFS_RAMKB: rd_byte = SIA_RAMKB_VAL;
      SIA_OFS_PORTS: rd_byte = pd;
      SIA_OFS_FEAT_LO: rd_byte = fe[7:0];
      SIA_OFS_FEAT_HI: rd_byte = fe[15:8];
      SIA_OFS_NODE_LO: rd_byte = nd[7:0];
      SIA_OFS_NODE_HI: rd_byte = nd[15:8];
      SIA_OFS_ALIAS_LO: rd_byte = al[7:0];
      SIA_OFS_ALIAS_HI: rd_byte = al[15:8];
      // unlock register bits carry no state and read zero
      default: rd_byte = 8'h00;
    endcase
  endfunction

  assign net_wr_ok = net_req.wr && wr_allow;

  always_comb
  begin
    node_next = node_reg;
    if (net_wr_ok && net_req.addr == SIA_OFS_NODE_LO)
      node_next[7:0] = net_req.wdata;
    if (net_wr_ok && net_req.addr == SIA_OFS_NODE_HI)
      node_next[15:8] = net_req.wdata;
  end

  // host write after config load in one cycle: host value wins
  always_comb
  begin
    alias_next = alias_reg;
    if (alias_take)
      alias_next = cfg_alias;
    if (host_req.wr && host_req.addr == SIA_OFS_ALIAS_LO)
      alias_next[7:0] = host_req.wdata;
    if (host_req.wr && host_req.addr == SIA_OFS_ALIAS_HI)
      alias_next[15:8] = host_req.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      node_reg <= SIA_NODE_RST;
    else
      node_reg <= node_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      alias_reg <= SIA_ALIAS_RST;
    else
      alias_reg <= alias_next;
  end

  // read data registered, valid the cycle after rd
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      net_rdata_reg <= 8'h00;
    else if (net_req.rd)
      net_rdata_reg <= rd_byte(net_req.addr, feat, ports, node_reg,
        alias_reg);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      host_rdata_reg <= 8'h00;
    else if (host_req.rd)
      host_rdata_reg <= rd_byte(host_req.addr, feat, ports, node_reg,
        alias_reg);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      net_done_reg <= 1'b0;
    else
      net_done_reg <= net_wr_ok;
  end

  assign net_rdata = net_rdata_reg;
  assign host_rdata = host_rdata_reg;
  assign net_wr_done = net_done_reg;
  assign node_addr = node_reg;
  assign match_alias = alias_reg;
  assign alias_active = link_ctrl[SIA_ALIAS_EN_BIT];

  AST_TYPE_READ: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_TYPE
    |=> net_rdata == SIA_TYPE_VAL)
    else $error("type code wrong");
  AST_TYPE_HOST: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_TYPE
    |=> host_rdata == SIA_TYPE_VAL)
    else $error("host type code wrong");
  AST_REV_READ: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_REV
    |=> host_rdata == SIA_REV_VAL)
    else $error("revision wrong");
  AST_REV_NET: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_REV
    |=> net_rdata == SIA_REV_VAL)
    else $error("network revision wrong");
  AST_BUILD_HI: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_BUILD_HI
    |=> net_rdata == SIA_BUILD_VAL[15:8])
    else $error("build high byte wrong");
  AST_BUILD_LO: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_BUILD_LO
    |=> host_rdata == SIA_BUILD_VAL[7:0])
    else $error("build low byte wrong");
  AST_MAPCNT: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_MAPCNT
    |=> host_rdata == 8'h08)
    else $error("mapping count wrong");
  AST_MAPCNT_NET: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_MAPCNT
    |=> net_rdata == 8'h08)
    else $error("network mapping count wrong");
  AST_BUFCNT: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_BUFCNT
    |=> net_rdata == 8'h08)
    else $error("buffer count wrong");
  AST_BUFCNT_HOST: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_BUFCNT
    |=> host_rdata == 8'h08)
    else $error("host buffer count wrong");
  AST_RAMKB: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_RAMKB
    |=> net_rdata == 8'h10)
    else $error("ram size wrong");
  AST_RAMKB_HOST: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_RAMKB
    |=> host_rdata == 8'h10)
    else $error("host ram size wrong");
  AST_PORTS: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_PORTS
    |=> host_rdata == 8'h0F)
    else $error("port descriptor wrong");
  AST_PORTS_NET: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_PORTS
    |=> net_rdata == 8'h0F)
    else $error("network port descriptor wrong");
  AST_FEAT_ZERO: assert property (
    @(posedge clk) disable iff (!rst_b)
    feat[5:4] == 2'h0 && feat[10:9] == 2'h0 && feat[15:12] == 4'h0
    && !feat[1])
    else $error("fixed feature bits wrong");
  AST_FCS_SEP: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_FEAT_LO
    |=> net_rdata[7] == FEAT_FCS_SEP)
    else $error("checksum counting bit wrong");
  AST_SYNC_ACT: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_FEAT_HI
    |=> host_rdata[0] == FEAT_SYNC_ACT)
    else $error("sync activation bit wrong");
  AST_NO_LRW: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_FEAT_HI
    |=> net_rdata[1] == 1'b0)
    else $error("combined command bit wrong");
  AST_NO_RW: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_FEAT_HI
    |=> host_rdata[2] == 1'b0)
    else $error("read write command bit wrong");
  AST_FIXED: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_FEAT_HI
    |=> net_rdata[3] == FEAT_FIXED)
    else $error("fixed configuration bit wrong");
  AST_NODE_HOST_RO: assert property (
    @(posedge clk) disable iff (!rst_b)
    !net_wr_ok
    |=> $stable(node_reg))
    else $error("node address changed without network write");
  AST_NODE_WRITE: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_wr_ok && net_req.addr == SIA_OFS_NODE_LO
    |=> node_reg[7:0] == $past(net_req.wdata))
    else $error("node address write lost");
  AST_NODE_HOST_READ: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.rd && host_req.addr == SIA_OFS_NODE_HI && !net_wr_ok
    |=> host_rdata == node_reg[15:8])
    else $error("host node read wrong");
  AST_ALIAS_NET_RO: assert property (
    @(posedge clk) disable iff (!rst_b)
    !host_req.wr && !alias_take
    |=> $stable(alias_reg))
    else $error("alias changed without host write");
  AST_ALIAS_HOST_WRITE: assert property (
    @(posedge clk) disable iff (!rst_b)
    host_req.wr && host_req.addr == SIA_OFS_ALIAS_LO
    |=> alias_reg[7:0] == $past(host_req.wdata))
    else $error("alias host write lost");
  AST_ALIAS_LOAD: assert property (
    @(posedge clk) disable iff (!rst_b)
    alias_take && !host_req.wr
    |=> alias_reg == $past(cfg_alias))
    else $error("alias load lost");
  AST_PROT_BLOCK: assert property (
    @(posedge clk) disable iff (!rst_b)
    prot_en && !unlocked && net_req.wr && net_req.addr == SIA_OFS_NODE_HI
    |=> !net_wr_done && $stable(node_reg))
    else $error("locked write took effect");
  AST_WR_DONE: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_wr_ok
    |=> net_wr_done)
    else $error("accepted write not reported");
  AST_UNLOCK_READ: assert property (
    @(posedge clk) disable iff (!rst_b)
    net_req.rd && net_req.addr == SIA_OFS_UNLOCK
    |=> net_rdata == 8'h00)
    else $error("unlock register not zero");
endmodule

// file: hdl/sia_wr_gate.sv
// frame-scoped write unlock for the network side
module sia_wr_gate
  import sia_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // network access
  input wire logic frame_end,
  input wire logic net_wr,
  input wire logic [15:0] net_addr,
  input wire logic prot_en,
  // result
  output logic wr_allow,
  output logic unlocked
);
  import sia_pkg::*;

  logic unlocked_reg;
  logic in_window;

  function automatic logic in_range(input logic [15:0] a,
    input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // the unlock register itself stays writable
  always_comb
  begin
    in_window = in_range(net_addr, SIA_PROT_A_LO, SIA_PROT_A_HI) ||
      in_range(net_addr, SIA_PROT_B_LO, SIA_PROT_B_HI);
  end

  assign wr_allow = !prot_en || unlocked_reg || !in_window ||
    (net_addr == SIA_OFS_UNLOCK);
  assign unlocked = unlocked_reg;

  // unlock lasts to the end of frame only; protection stays armed
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      unlocked_reg <= 1'b0;
    else if (net_wr && net_addr == SIA_OFS_UNLOCK)
      unlocked_reg <= 1'b1;
    else if (frame_end)
      unlocked_reg <= 1'b0;
  end

  AST_UNLOCK_CLEARS: assert property (
    @(posedge clk) disable iff (!rst_b)
    frame_end && !(net_wr && net_addr == SIA_OFS_UNLOCK) |=> !unlocked_reg)
    else $error("unlock survived frame end");
  AST_BLOCKED: assert property (
    @(posedge clk) disable iff (!rst_b)
    prot_en && !unlocked_reg && net_addr == SIA_OFS_NODE_LO |-> !wr_allow)
    else $error("protected write allowed");
endmodule

// file: verif/sia_agent.sv
// network frame processor and host port model issuing byte accesses
module sia_agent
(
  // clock
  input wire logic clk,
  // requests toward the register bank
  output sia_pkg::sia_req_t net_req,
  output sia_pkg::sia_req_t host_req,
  output logic net_frame_end
);
  timeunit 1ns;
  timeprecision 1ns;
  import sia_pkg::*;

  initial
  begin
    net_req = '0;
    host_req = '0;
    net_frame_end = 1'b0;
  end

  // request held from one edge to the next, where it is taken
  task automatic drive(input logic host, input logic rd, input logic wr,
                       input logic [15:0] a, input logic [7:0] d);
    sia_req_t r;
    r = '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge clk);
    if (host)
      host_req <= r;
    else
      net_req <= r;
  endtask

  // released lines show inverted values so stale data never matches
  task automatic release_all();
    @(posedge clk);
    net_req <= '{1'b0, 1'b0, ~net_req.addr, ~net_req.wdata};
    host_req <= '{1'b0, 1'b0, ~host_req.addr, ~host_req.wdata};
  endtask

  task automatic end_frame();
    @(posedge clk);
    net_frame_end <= 1'b1;
    @(posedge clk);
    net_frame_end <= 1'b0;
  endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the identity and address register bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sia_pkg::*;

  logic clk;
  logic rst_b;
  logic cfg_load;
  logic prot_en;
  logic [15:0] cfg_alias;
  logic [31:0] link_ctrl;
  sia_req_t net_req;
  sia_req_t host_req;
  logic net_frame_end;
  logic [7:0] net_rdata;
  logic [7:0] host_rdata;
  logic net_wr_done;
  logic alias_active;
  logic [15:0] node_addr;
  logic [15:0] match_alias;
  int fail_count;
  int tests_run;

  sia_agent i_agent (.clk(clk), .net_req(net_req), .host_req(host_req),
    .net_frame_end(net_frame_end));

  sia_regs i_dut (.clk(clk), .rst_b(rst_b), .net_req(net_req),
    .net_frame_end(net_frame_end), .net_rdata(net_rdata),
    .net_wr_done(net_wr_done), .host_req(host_req),
    .host_rdata(host_rdata), .cfg_load(cfg_load), .cfg_alias(cfg_alias),
    .link_ctrl(link_ctrl), .prot_en(prot_en), .node_addr(node_addr),
    .match_alias(match_alias), .alias_active(alias_active));

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic host, input logic [15:0] a,
                    output logic [7:0] d);
    i_agent.drive(host, 1'b1, 1'b0, a, 8'h00);
    i_agent.release_all();
    #1;
    d = host ? host_rdata : net_rdata;
  endtask

  task automatic wr(input logic host, input logic [15:0] a,
                    input logic [7:0] v, output logic [7:0] done);
    i_agent.drive(host, 1'b0, 1'b1, a, v);
    i_agent.release_all();
    #1;
    done = {7'h00, net_wr_done};
  endtask

  task automatic t_ident();
    logic [7:0] exp [10];
    logic [7:0] d;
    logic [7:0] done;
    // both ports mii, feature bits 0,2,3,6,7,8 set by default
    exp = '{SIA_TYPE_VAL, SIA_REV_VAL, SIA_BUILD_VAL[7:0],
      SIA_BUILD_VAL[15:8], 8'h08, 8'h08, 8'h10, 8'h0F, 8'hCD, 8'h01};
    for (int i = 0; i < 10; i++)
    begin
      wr(i[0], 16'(i), 8'hFF, done);
      rd(1'b0, 16'(i), d);
      chk8("net id", exp[i], d);
      rd(1'b1, 16'(i), d);
      chk8("host id", exp[i], d);
    end
    $display("test ident done");
  endtask

  task automatic t_node();
    logic [7:0] d;
    logic [7:0] done;
    wr(1'b0, SIA_OFS_NODE_LO, 8'h34, done);
    chk8("node wr done", 8'h01, done);
    wr(1'b0, SIA_OFS_NODE_HI, 8'h12, done);
    wr(1'b1, SIA_OFS_NODE_LO, 8'hAA, done);
    chk16("node addr", 16'h1234, node_addr);
    rd(1'b1, SIA_OFS_NODE_HI, d);
    chk8("host node hi", 8'h12, d);
    rd(1'b0, SIA_OFS_FEAT_HI, d);
    chk8("feature high", 8'h01, d);
    rd(1'b1, SIA_OFS_FEAT_LO, d);
    chk8("feature low", 8'hCD, d);
    $display("test node done");
  endtask

  task automatic t_alias();
    logic [7:0] d;
    logic [7:0] done;
    @(posedge clk);
    cfg_alias <= 16'hBEEF;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    cfg_alias <= 16'h1111;
    @(posedge clk);
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    #1;
    chk16("alias load", 16'hBEEF, match_alias);
    wr(1'b1, SIA_OFS_ALIAS_LO, 8'h77, done);
    wr(1'b0, SIA_OFS_ALIAS_HI, 8'h55, done);
    rd(1'b0, SIA_OFS_ALIAS_LO, d);
    chk8("net alias lo", 8'h77, d);
    chk16("alias", 16'hBE77, match_alias);
    @(posedge clk);
    link_ctrl <= 32'h0100_0000;
    #1;
    chk8("alias on", 8'h01, {7'h00, alias_active});
    @(posedge clk);
    link_ctrl <= 32'hFEFF_FFFF;
    #1;
    chk8("alias off", 8'h00, {7'h00, alias_active});
    $display("test alias done");
  endtask

  task automatic t_prot();
    logic [7:0] d;
    logic [7:0] done;
    @(posedge clk);
    prot_en <= 1'b1;
    wr(1'b0, SIA_OFS_NODE_LO, 8'h99, done);
    chk8("locked wr", 8'h00, done);
    wr(1'b0, 16'h0137, 8'h00, done);
    chk8("wr 0137", 8'h00, done);
    wr(1'b0, 16'h0138, 8'h00, done);
    chk8("wr 0138", 8'h01, done);
    wr(1'b0, 16'h013A, 8'h00, done);
    chk8("wr 013A", 8'h00, done);
    wr(1'b0, 16'h0F10, 8'h00, done);
    chk8("wr 0F10", 8'h01, done);
    i_agent.drive(1'b0, 1'b0, 1'b1, SIA_OFS_UNLOCK, 8'hC3);
    i_agent.drive(1'b0, 1'b0, 1'b1, SIA_OFS_NODE_LO, 8'h99);
    i_agent.release_all();
    #1;
    chk8("unlocked wr", 8'h01, {7'h00, net_wr_done});
    chk16("node unlocked", 16'h1299, node_addr);
    i_agent.end_frame();
    wr(1'b0, SIA_OFS_NODE_HI, 8'h66, done);
    chk8("relocked wr", 8'h00, done);
    chk16("node kept", 16'h1299, node_addr);
    rd(1'b0, SIA_OFS_UNLOCK, d);
    chk8("unlock reads", 8'h00, d);
    @(posedge clk);
    prot_en <= 1'b0;
    $display("test prot done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // every access has a fixed latency, so only a hang can trip this
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("timeout reached");
    test_done();
  end

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_b = 1'b0;
    cfg_load = 1'b0;
    cfg_alias = 16'h0000;
    link_ctrl = 32'h0000_0000;
    prot_en = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_ident();
    t_node();
    t_alias();
    t_prot();
    test_done();
  end
endmodule
